// ===== src/rrf_pkg.sv
// Purpose: shared constants for the register file with rename buffers
// Assumes: single processor clock, active-low asynchronous reset
// Notes: field layouts of the status/control and machine state words
package rrf_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int GP_REGS = 32;
  localparam int GP_W = 32;
  localparam int GP_REN = 12;
  localparam int FP_REGS = 32;
  localparam int FP_W = 64;
  localparam int FP_REN = 8;
  localparam int CR_FIELDS = 8;
  localparam int CR_FW = 4;
  localparam int CR_REN = 8;
  localparam int WORD_W = 32;
  localparam int IMM_W = 16;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] CR_RESET = 32'h0000_0000;
  localparam logic [31:0] FSC_RESET = 32'h0000_0000;
  localparam logic [31:0] MSW_RESET = 32'h0000_0000;
  localparam logic [31:0] SR_RESET = 32'h0000_0000;
  // ****************************************
  // machine state word: privilege bit, 1 = user
  // ****************************************
  localparam int MSW_PRIV_BIT = 1;
  // ****************************************
  // float status/control layout
  // ****************************************
  localparam int FSC_EXC_N = 5;
  localparam int FSC_RND_LSB = 0;
  localparam int FSC_EN_LSB = 2;
  localparam int FSC_ST_LSB = 8;
  localparam int FSC_SUM_BIT = 13;
  localparam int FSC_ENSUM_BIT = 14;
  // ****************************************
  // special register indices
  // ****************************************
  localparam int SR_SCR_N = 4;
  localparam logic [9:0] SR_SCR_BASE = 10'h010;
  localparam logic [9:0] SR_SAVE_IDX = 10'h01a;
endpackage : rrf_pkg

// ===== src/rrf_ren_if.sv
// Purpose: link between the register file and one rename buffer pool
// Assumes: all signals in the clock domain of the pool
// Notes: two lookup ports
`timescale 1ns/100ps
`default_nettype none
interface rrf_ren_if #(parameter int W = 32, parameter int AW = 5, parameter int TW = 4);
  logic alloc_req;
  logic [AW-1:0] alloc_dst;
  logic alloc_ok;
  logic [TW-1:0] alloc_tag;
  logic res_we;
  logic [TW-1:0] res_tag;
  logic [W-1:0] res_data;
  logic commit_en;
  logic cmt_valid;
  logic [AW-1:0] cmt_dst;
  logic [W-1:0] cmt_data;
  logic flush;
  logic [1:0][AW-1:0] lk_idx;
  logic [1:0] lk_hit;
  logic [1:0] lk_pend;
  logic [1:0][W-1:0] lk_data;
  modport pool (input alloc_req, alloc_dst, res_we, res_tag, res_data, commit_en, flush,
    lk_idx, output alloc_ok, alloc_tag, cmt_valid, cmt_dst, cmt_data, lk_hit, lk_pend,
    lk_data);
  modport user (output alloc_req, alloc_dst, res_we, res_tag, res_data, commit_en, flush,
    lk_idx, input alloc_ok, alloc_tag, cmt_valid, cmt_dst, cmt_data, lk_hit, lk_pend,
    lk_data);
endinterface : rrf_ren_if
`default_nettype wire

// ===== src/rrf_rename_pool.sv
// Purpose: circular pool of rename buffers, allocated and retired in order
// Assumes: result tags name allocated entries
// Notes: commit of the head goes ahead in a flush cycle, the rest is dropped
`timescale 1ns/100ps
`default_nettype none
module rrf_rename_pool #(
  parameter int N = 8,
  parameter int W = 32,
  parameter int AW = 5,
  parameter int TW = 3
) (
  input wire logic clock,
  input wire logic resetn,
  rrf_ren_if.pool rp
);
  localparam logic [TW:0] FULL = (TW+1)'(N);
  logic [N-1:0] valid_q;
  logic [N-1:0] done_q;
  logic [AW-1:0] dst_q [N];
  logic [W-1:0] data_q [N];
  logic [TW-1:0] head_q;
  logic [TW-1:0] tail_q;
  logic [TW:0] count_q;

  function automatic logic [TW-1:0] wrap_add(input logic [TW-1:0] p, input int k);
    int s;
    s = int'(p) + k;
    if (s >= N) s = s - N;
    return s[TW-1:0];
  endfunction : wrap_add

  wire do_alloc = rp.alloc_req && (count_q != FULL) && !rp.flush;
  assign rp.alloc_ok = (count_q != FULL);
  assign rp.alloc_tag = tail_q;
  // retire only the oldest, finished entry
  assign rp.cmt_valid = rp.commit_en && valid_q[head_q] && done_q[head_q];
  assign rp.cmt_dst = dst_q[head_q];
  assign rp.cmt_data = data_q[head_q];

  // youngest matching entry overrides older ones
  always_comb begin
    logic [TW-1:0] e;
    e = '0;
    rp.lk_hit = '0;
    rp.lk_pend = '0;
    rp.lk_data = '0;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < N; k++) begin
        e = wrap_add(head_q, k);
        if ((k < int'(count_q)) && valid_q[e] && (dst_q[e] == rp.lk_idx[p])) begin
          rp.lk_hit[p] = done_q[e];
          rp.lk_pend[p] = !done_q[e];
          rp.lk_data[p] = data_q[e];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      valid_q <= '0;
      done_q <= '0;
      head_q <= '0;
      tail_q <= '0;
      count_q <= '0;
      for (int i = 0; i < N; i++) begin
        dst_q[i] <= '0;
        data_q[i] <= '0;
      end
    end else if (rp.flush) begin
      valid_q <= '0;
      done_q <= '0;
      head_q <= '0;
      tail_q <= '0;
      count_q <= '0;
    end else begin
      if (do_alloc) begin
        valid_q[tail_q] <= 1'b1;
        done_q[tail_q] <= 1'b0;
        dst_q[tail_q] <= rp.alloc_dst;
        tail_q <= wrap_add(tail_q, 1);
      end
      if (rp.res_we && valid_q[rp.res_tag]) begin
        done_q[rp.res_tag] <= 1'b1;
        data_q[rp.res_tag] <= rp.res_data;
      end
      if (rp.cmt_valid) begin
        valid_q[head_q] <= 1'b0;
        head_q <= wrap_add(head_q, 1);
      end
      count_q <= count_q + {{TW{1'b0}}, do_alloc} - {{TW{1'b0}}, rp.cmt_valid};
    end
  end
endmodule : rrf_rename_pool
`default_nettype wire

// ===== src/rrf_regfile.sv
// Purpose: architected registers with rename buffers and privilege checks
// Assumes: one instruction's software access per cycle, synchronous inputs
// Notes: all read answers appear one cycle after the request
// How it works
// - 32 integer registers, 32 bits each
// - 12 hidden integer rename buffers
// - 32 float registers, 64 bits each
// - eight float rename buffers
// - float entries hold single or double
// - condition word: eight 4-bit fields
// - eight condition rename buffers
// - two sources, separate destination, immediate option
// - access depends on privilege bit
// - supervisor-only operations refused in user mode
// - 64-bit-only instructions raise illegal exception
// - non-float registers are 32 bits
// - special registers selected by numeric index
// - status/control holds status, summary, enables, rounding
// - state word saved on exception, restored after
`timescale 1ns/100ps
`default_nettype none
module rrf_regfile import rrf_pkg::*; #(
  parameter int GPN = GP_REN,
  parameter int FPN = FP_REN,
  parameter int CRN = CR_REN
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic gp_alloc_req,
  input wire logic [4:0] gp_alloc_dst,
  output logic gp_alloc_ok,
  output logic [3:0] gp_alloc_tag,
  input wire logic gp_res_we,
  input wire logic [3:0] gp_res_tag,
  input wire logic [GP_W-1:0] gp_res_data,
  input wire logic gp_commit,
  input wire logic [4:0] gp_src_a,
  input wire logic [4:0] gp_src_b,
  input wire logic gp_use_imm,
  input wire logic [IMM_W-1:0] gp_imm,
  output logic [GP_W-1:0] gp_dat_a,
  output logic [GP_W-1:0] gp_dat_b,
  output logic gp_rdy_a,
  output logic gp_rdy_b,
  input wire logic fp_alloc_req,
  input wire logic [4:0] fp_alloc_dst,
  output logic fp_alloc_ok,
  output logic [2:0] fp_alloc_tag,
  input wire logic fp_res_we,
  input wire logic [2:0] fp_res_tag,
  input wire logic [FP_W-1:0] fp_res_data,
  input wire logic fp_res_single,
  input wire logic fp_commit,
  input wire logic [4:0] fp_src_a,
  input wire logic [4:0] fp_src_b,
  output logic [FP_W-1:0] fp_dat_a,
  output logic [FP_W-1:0] fp_dat_b,
  output logic fp_single_a,
  output logic fp_single_b,
  output logic fp_rdy_a,
  output logic fp_rdy_b,
  input wire logic cr_alloc_req,
  input wire logic [2:0] cr_alloc_fld,
  output logic cr_alloc_ok,
  output logic [2:0] cr_alloc_tag,
  input wire logic cr_res_we,
  input wire logic [2:0] cr_res_tag,
  input wire logic [CR_FW-1:0] cr_res_data,
  input wire logic cr_commit,
  input wire logic [2:0] cr_fld_a,
  input wire logic [2:0] cr_fld_b,
  output logic [CR_FW-1:0] cr_test_a,
  output logic [CR_FW-1:0] cr_test_b,
  output logic cr_rdy_a,
  output logic cr_rdy_b,
  input wire logic flush,
  input wire logic mv_cr_we,
  input wire logic [CR_FIELDS-1:0] mv_cr_mask,
  input wire logic [WORD_W-1:0] mv_cr_wdata,
  output logic [WORD_W-1:0] condition_fields,
  input wire logic sr_we,
  input wire logic sr_re,
  input wire logic [9:0] sr_index,
  input wire logic [WORD_W-1:0] sr_wdata,
  output logic [WORD_W-1:0] sr_rdata,
  output logic sr_rvalid,
  input wire logic fsc_we,
  input wire logic [WORD_W-1:0] fsc_wdata,
  input wire logic [FSC_EXC_N-1:0] fp_exc_set,
  output logic [WORD_W-1:0] float_status_control,
  input wire logic msw_we,
  input wire logic [WORD_W-1:0] msw_wdata,
  input wire logic exc_take,
  input wire logic exc_return,
  output logic [WORD_W-1:0] machine_state_word,
  input wire logic op_64bit,
  output logic illegal_op,
  output logic priv_fault
);
  // ****************************************
  // storage
  // ****************************************
  logic [GP_W-1:0] igr_q [GP_REGS];
  logic [FP_W-1:0] flr_q [FP_REGS];
  logic [FP_REGS-1:0] fsg_q;
  logic [WORD_W-1:0] cr_q;
  logic [WORD_W-1:0] cr_d;
  logic [WORD_W-1:0] fsc_q;
  logic [WORD_W-1:0] fsc_d;
  logic [WORD_W-1:0] msw_q;
  logic [WORD_W-1:0] save_q;
  logic [WORD_W-1:0] scr_q [SR_SCR_N];
  logic [GP_W-1:0] gp_dat_a_q, gp_dat_b_q;
  logic [FP_W-1:0] fp_dat_a_q, fp_dat_b_q;
  logic [CR_FW-1:0] cr_test_a_q, cr_test_b_q;
  logic [WORD_W-1:0] sr_rdata_q;
  logic [3:0] gp_tag_q;
  logic [2:0] fp_tag_q, cr_tag_q;
  logic gp_ok_q, fp_ok_q, cr_ok_q, fsa_q, fsb_q, sr_rvalid_q, illegal_q, fault_q;
  logic gp_rdy_a_q, gp_rdy_b_q, fp_rdy_a_q, fp_rdy_b_q, cr_rdy_a_q, cr_rdy_b_q;

  function automatic logic [CR_FW-1:0] cr_field(input logic [WORD_W-1:0] w,
                                                input logic [2:0] f);
    return w[WORD_W-1-CR_FW*int'(f) -: CR_FW];
  endfunction : cr_field

  // ****************************************
  // rename pools
  // ****************************************
  rrf_ren_if #(.W(GP_W), .AW(5), .TW(4)) gp_if ();
  rrf_ren_if #(.W(FP_W+1), .AW(5), .TW(3)) fp_if ();
  rrf_ren_if #(.W(CR_FW), .AW(3), .TW(3)) cr_if ();

  rrf_rename_pool #(.N(GPN), .W(GP_W), .AW(5), .TW(4)) u_gp_pool (
    .clock(clock), .resetn(resetn), .rp(gp_if.pool));
  rrf_rename_pool #(.N(FPN), .W(FP_W+1), .AW(5), .TW(3)) u_fp_pool (
    .clock(clock), .resetn(resetn), .rp(fp_if.pool));
  rrf_rename_pool #(.N(CRN), .W(CR_FW), .AW(3), .TW(3)) u_cr_pool (
    .clock(clock), .resetn(resetn), .rp(cr_if.pool));

  // exception entry drops all speculative results
  wire spec_flush = flush || exc_take;

  assign gp_if.alloc_req = gp_alloc_req;
  assign gp_if.alloc_dst = gp_alloc_dst;
  assign gp_if.res_we = gp_res_we;
  assign gp_if.res_tag = gp_res_tag;
  assign gp_if.res_data = gp_res_data;
  assign gp_if.commit_en = gp_commit;
  assign gp_if.flush = spec_flush;
  assign gp_if.lk_idx = {gp_src_b, gp_src_a};
  assign fp_if.alloc_req = fp_alloc_req;
  assign fp_if.alloc_dst = fp_alloc_dst;
  assign fp_if.res_we = fp_res_we;
  assign fp_if.res_tag = fp_res_tag;
  assign fp_if.res_data = {fp_res_single, fp_res_data};
  assign fp_if.commit_en = fp_commit;
  assign fp_if.flush = spec_flush;
  assign fp_if.lk_idx = {fp_src_b, fp_src_a};
  assign cr_if.alloc_req = cr_alloc_req;
  assign cr_if.alloc_dst = cr_alloc_fld;
  assign cr_if.res_we = cr_res_we;
  assign cr_if.res_tag = cr_res_tag;
  assign cr_if.res_data = cr_res_data;
  assign cr_if.commit_en = cr_commit;
  assign cr_if.flush = spec_flush;
  assign cr_if.lk_idx = {cr_fld_b, cr_fld_a};

  // ****************************************
  // operand selection
  // ****************************************
  wire [GP_W-1:0] imm_ext = {{(GP_W-IMM_W){gp_imm[IMM_W-1]}}, gp_imm};
  wire [GP_W-1:0] gp_a_d = gp_if.lk_hit[0] ? gp_if.lk_data[0] : igr_q[gp_src_a];
  wire [GP_W-1:0] gp_b_reg = gp_if.lk_hit[1] ? gp_if.lk_data[1] : igr_q[gp_src_b];
  wire [GP_W-1:0] gp_b_d = gp_use_imm ? imm_ext : gp_b_reg;
  wire gp_b_rdy = gp_use_imm || !gp_if.lk_pend[1];
  wire [FP_W:0] fp_a_d = fp_if.lk_hit[0] ? fp_if.lk_data[0] : {fsg_q[fp_src_a],
    flr_q[fp_src_a]};
  wire [FP_W:0] fp_b_d = fp_if.lk_hit[1] ? fp_if.lk_data[1] : {fsg_q[fp_src_b],
    flr_q[fp_src_b]};
  wire [CR_FW-1:0] cr_a_d = cr_if.lk_hit[0] ? cr_if.lk_data[0] : cr_field(cr_q, cr_fld_a);
  wire [CR_FW-1:0] cr_b_d = cr_if.lk_hit[1] ? cr_if.lk_data[1] : cr_field(cr_q, cr_fld_b);

  // ****************************************
  // privilege and legality
  // ****************************************
  wire user_mode = msw_q[MSW_PRIV_BIT];
  wire sr_hit_scr = (sr_index >= SR_SCR_BASE) &&
                    (sr_index < SR_SCR_BASE + 10'(SR_SCR_N));
  wire sr_hit_save = (sr_index == SR_SAVE_IDX);
  wire [1:0] scr_sel = 2'(sr_index - SR_SCR_BASE);
  // every mapped special register here is supervisor-only
  wire sup_req = msw_we || ((sr_we || sr_re) && (sr_hit_scr || sr_hit_save));
  wire refuse_priv = user_mode && sup_req && !op_64bit;
  wire legal = !op_64bit && !refuse_priv;
  wire msw_wr = msw_we && legal;
  wire sr_wr = sr_we && legal;
  wire sr_rd = sr_re && legal;
  wire [WORD_W-1:0] sr_rd_d = sr_hit_save ? save_q : (sr_hit_scr ? scr_q[scr_sel] : '0);

  // ****************************************
  // condition word update
  // ****************************************
  always_comb begin
    cr_d = cr_q;
    if (mv_cr_we && !op_64bit) begin
      for (int i = 0; i < CR_FIELDS; i++) begin
        if (mv_cr_mask[i]) begin
          cr_d[WORD_W-1-CR_FW*i -: CR_FW] = mv_cr_wdata[WORD_W-1-CR_FW*i -: CR_FW];
        end
      end
    end
    if (cr_if.cmt_valid) begin
      cr_d[WORD_W-1-CR_FW*int'(cr_if.cmt_dst) -: CR_FW] = cr_if.cmt_data;
    end
  end

  // ****************************************
  // float status/control: hardware sets win over a write
  // ****************************************
  always_comb begin
    fsc_d = (fsc_we && !op_64bit) ? fsc_wdata : fsc_q;
    fsc_d[FSC_ST_LSB +: FSC_EXC_N] = fsc_d[FSC_ST_LSB +: FSC_EXC_N] | fp_exc_set;
    fsc_d[FSC_SUM_BIT] = |fsc_d[FSC_ST_LSB +: FSC_EXC_N];
    fsc_d[FSC_ENSUM_BIT] = |(fsc_d[FSC_ST_LSB +: FSC_EXC_N] & fsc_d[FSC_EN_LSB +: FSC_EXC_N]);
  end

  // ****************************************
  // architected state
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < GP_REGS; i++) igr_q[i] <= '0;
      for (int i = 0; i < FP_REGS; i++) flr_q[i] <= '0;
      fsg_q <= '0;
    end else begin
      if (gp_if.cmt_valid) igr_q[gp_if.cmt_dst] <= gp_if.cmt_data;
      if (fp_if.cmt_valid) begin
        flr_q[fp_if.cmt_dst] <= fp_if.cmt_data[FP_W-1:0];
        fsg_q[fp_if.cmt_dst] <= fp_if.cmt_data[FP_W];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cr_q <= CR_RESET;
      fsc_q <= FSC_RESET;
      msw_q <= MSW_RESET;
      save_q <= SR_RESET;
      for (int i = 0; i < SR_SCR_N; i++) scr_q[i] <= SR_RESET;
    end else begin
      cr_q <= cr_d;
      fsc_q <= fsc_d;
      if (exc_take) begin
        save_q <= msw_q;
        msw_q[MSW_PRIV_BIT] <= 1'b0;
      end else if (exc_return) begin
        msw_q <= save_q;
      end else if (msw_wr) begin
        msw_q <= msw_wdata;
      end
      if (sr_wr && sr_hit_save && !exc_take) save_q <= sr_wdata;
      if (sr_wr && sr_hit_scr) scr_q[scr_sel] <= sr_wdata;
    end
  end

  // ****************************************
  // registered answers
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gp_dat_a_q <= '0;
      gp_dat_b_q <= '0;
      fp_dat_a_q <= '0;
      fp_dat_b_q <= '0;
      fsa_q <= 1'b0;
      fsb_q <= 1'b0;
      cr_test_a_q <= '0;
      cr_test_b_q <= '0;
      {gp_rdy_a_q, gp_rdy_b_q, fp_rdy_a_q, fp_rdy_b_q, cr_rdy_a_q, cr_rdy_b_q} <= '0;
      {gp_ok_q, fp_ok_q, cr_ok_q} <= '0;
      gp_tag_q <= '0;
      fp_tag_q <= '0;
      cr_tag_q <= '0;
      sr_rdata_q <= '0;
      sr_rvalid_q <= 1'b0;
      illegal_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      gp_dat_a_q <= gp_a_d;
      gp_dat_b_q <= gp_b_d;
      gp_rdy_a_q <= !gp_if.lk_pend[0];
      gp_rdy_b_q <= gp_b_rdy;
      {fsa_q, fp_dat_a_q} <= fp_a_d;
      {fsb_q, fp_dat_b_q} <= fp_b_d;
      fp_rdy_a_q <= !fp_if.lk_pend[0];
      fp_rdy_b_q <= !fp_if.lk_pend[1];
      cr_test_a_q <= cr_a_d;
      cr_test_b_q <= cr_b_d;
      cr_rdy_a_q <= !cr_if.lk_pend[0];
      cr_rdy_b_q <= !cr_if.lk_pend[1];
      gp_ok_q <= gp_alloc_req && gp_if.alloc_ok && !spec_flush;
      fp_ok_q <= fp_alloc_req && fp_if.alloc_ok && !spec_flush;
      cr_ok_q <= cr_alloc_req && cr_if.alloc_ok && !spec_flush;
      gp_tag_q <= gp_if.alloc_tag;
      fp_tag_q <= fp_if.alloc_tag;
      cr_tag_q <= cr_if.alloc_tag;
      sr_rdata_q <= sr_rd ? sr_rd_d : '0;
      sr_rvalid_q <= sr_rd;
      illegal_q <= op_64bit;
      fault_q <= refuse_priv;
    end
  end

  assign gp_alloc_ok = gp_ok_q;
  assign gp_alloc_tag = gp_tag_q;
  assign gp_dat_a = gp_dat_a_q;
  assign gp_dat_b = gp_dat_b_q;
  assign gp_rdy_a = gp_rdy_a_q;
  assign gp_rdy_b = gp_rdy_b_q;
  assign fp_alloc_ok = fp_ok_q;
  assign fp_alloc_tag = fp_tag_q;
  assign fp_dat_a = fp_dat_a_q;
  assign fp_dat_b = fp_dat_b_q;
  assign fp_single_a = fsa_q;
  assign fp_single_b = fsb_q;
  assign fp_rdy_a = fp_rdy_a_q;
  assign fp_rdy_b = fp_rdy_b_q;
  assign cr_alloc_ok = cr_ok_q;
  assign cr_alloc_tag = cr_tag_q;
  assign cr_test_a = cr_test_a_q;
  assign cr_test_b = cr_test_b_q;
  assign cr_rdy_a = cr_rdy_a_q;
  assign cr_rdy_b = cr_rdy_b_q;
  assign condition_fields = cr_q;
  assign sr_rdata = sr_rdata_q;
  assign sr_rvalid = sr_rvalid_q;
  assign float_status_control = fsc_q;
  assign machine_state_word = msw_q;
  assign illegal_op = illegal_q;
  assign priv_fault = fault_q;
endmodule : rrf_regfile
`default_nettype wire

// ===== tb/rrf_props.sv
// Purpose: port-level checks of the register file with rename buffers
// Assumes: one clock, active-low asynchronous reset
// Notes: bound to every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module rrf_props import rrf_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic op_64bit,
  input wire logic illegal_op,
  input wire logic sr_we,
  input wire logic sr_re,
  input wire logic [9:0] sr_index,
  input wire logic [WORD_W-1:0] machine_state_word,
  input wire logic priv_fault,
  input wire logic sr_rvalid,
  input wire logic [WORD_W-1:0] float_status_control,
  input wire logic exc_take,
  input wire logic flush,
  input wire logic gp_alloc_req,
  input wire logic gp_alloc_ok,
  input wire logic gp_use_imm,
  input wire logic [IMM_W-1:0] gp_imm,
  input wire logic [GP_W-1:0] gp_dat_b,
  input wire logic mv_cr_we,
  input wire logic [CR_FIELDS-1:0] mv_cr_mask,
  input wire logic [WORD_W-1:0] mv_cr_wdata,
  input wire logic cr_commit,
  input wire logic [WORD_W-1:0] condition_fields
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_illegal_after_op: assert property (op_64bit |=> illegal_op)
    else $error("no illegal op pulse");
  a_user_sr_fault: assert property (sr_we && !op_64bit && machine_state_word[MSW_PRIV_BIT]
    && sr_index == SR_SCR_BASE |=> priv_fault) else $error("user write not refused");
  a_user_read_refused: assert property (sr_re && machine_state_word[MSW_PRIV_BIT]
    && sr_index == SR_SAVE_IDX |=> !sr_rvalid) else $error("user read answered");
  a_fsc_summary: assert property (float_status_control[FSC_SUM_BIT]
    == |float_status_control[FSC_ST_LSB +: FSC_EXC_N]) else $error("summary wrong");
  a_exc_supervisor: assert property (exc_take |=> !machine_state_word[MSW_PRIV_BIT])
    else $error("exception not supervisor");
  a_flush_refuses_alloc: assert property (gp_alloc_req && flush |=> !gp_alloc_ok)
    else $error("alloc during flush");
  a_imm_sign_ext: assert property (gp_use_imm |=> gp_dat_b ==
    {{(GP_W-IMM_W){$past(gp_imm[IMM_W-1])}}, $past(gp_imm)}) else $error("bad immediate");
  a_cr_move_lands: assert property (mv_cr_we && !op_64bit && !cr_commit && mv_cr_mask == 8'hff
    |=> condition_fields == $past(mv_cr_wdata)) else $error("move lost");
  a_rvalid_cause: assert property (sr_rvalid |-> $past(sr_re))
    else $error("stray read valid");
  c_priv: cover property (priv_fault);
  c_illegal: cover property (illegal_op);
  c_exc: cover property (exc_take ##1 !machine_state_word[MSW_PRIV_BIT]);
endmodule : rrf_props
bind rrf_regfile rrf_props u_props (.*);
`default_nettype wire

// ===== tb/risc_register_file_rename_test.sv
// Purpose: directed scenarios for the register file with rename buffers
// Assumes: inputs change 1 ns after the rising edge
// Notes: answers are checked one edge after each request
`timescale 1ns/100ps
`default_nettype none
module risc_register_file_rename_test import rrf_pkg::*;;
  logic clock = 0, resetn = 0, flush = 0, op_64bit = 0;
  logic gp_alloc_req = 0, gp_res_we = 0, gp_commit = 0, gp_use_imm = 0;
  logic [4:0] gp_alloc_dst = '0, gp_src_a = '0, gp_src_b = '0;
  logic [3:0] gp_res_tag = '0, gp_alloc_tag;
  logic [31:0] gp_res_data = '0, gp_dat_a, gp_dat_b;
  logic [15:0] gp_imm = '0;
  logic fp_alloc_req = 0, fp_res_we = 0, fp_res_single = 0, fp_commit = 0;
  logic [4:0] fp_alloc_dst = '0, fp_src_a = '0, fp_src_b = '0;
  logic [2:0] fp_res_tag = '0, fp_alloc_tag, cr_alloc_tag;
  logic [63:0] fp_res_data = '0, fp_dat_a, fp_dat_b;
  logic cr_alloc_req = 0, cr_res_we = 0, cr_commit = 0, mv_cr_we = 0;
  logic [2:0] cr_alloc_fld = '0, cr_res_tag = '0, cr_fld_a = '0, cr_fld_b = '0;
  logic [3:0] cr_res_data = '0, cr_test_a, cr_test_b;
  logic [7:0] mv_cr_mask = '0;
  logic [31:0] mv_cr_wdata = '0, sr_wdata = '0, fsc_wdata = '0, msw_wdata = '0;
  logic sr_we = 0, sr_re = 0, fsc_we = 0, msw_we = 0, exc_take = 0, exc_return = 0;
  logic [9:0] sr_index = '0;
  logic [4:0] fp_exc_set = '0;
  logic gp_alloc_ok, gp_rdy_a, gp_rdy_b, fp_alloc_ok, fp_single_a, fp_single_b;
  logic fp_rdy_a, fp_rdy_b, cr_alloc_ok, cr_rdy_a, cr_rdy_b, sr_rvalid, illegal_op, priv_fault;
  logic [31:0] condition_fields, sr_rdata, float_status_control, machine_state_word;
  int mismatches = 0, num_checks = 0;
  rrf_regfile dut (.*);
  initial begin
    forever #5 clock = ~clock;
  end
  task tick;
    @(posedge clock);
    #1;
  endtask : tick
  task chk(input logic [64:0] got, input logic [64:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task sr_acc(input logic we, input logic [9:0] idx, input logic [31:0] d);
    sr_we = we;
    sr_re = !we;
    sr_index = idx;
    sr_wdata = d;
    tick;
  endtask : sr_acc
  task t_gp;
    gp_alloc_req = 1; gp_alloc_dst = 5'h07;
    repeat (GP_REN) begin
      tick;
      chk(gp_alloc_ok, 1);
    end
    tick;
    chk(gp_alloc_ok, 0);
    flush = 1;
    tick;
    chk(gp_alloc_ok, 0);
    tick;
    chk(gp_alloc_ok, 0);
    flush = 0; gp_alloc_dst = 5'h05; gp_src_a = 5'h05;
    tick;
    gp_alloc_req = 0; gp_res_tag = gp_alloc_tag;
    chk({gp_alloc_ok, gp_alloc_tag}, 5'h10);
    tick;
    chk(gp_rdy_a, 0);
    gp_res_we = 1; gp_res_data = 32'hcafe_0005;
    tick;
    gp_res_we = 0; gp_commit = 1;
    tick;
    chk({gp_rdy_a, gp_dat_a}, 33'h1_cafe_0005);
    gp_commit = 0; gp_alloc_req = 1;
    tick;
    gp_alloc_req = 0; gp_res_we = 1; gp_res_tag = gp_alloc_tag; gp_res_data = 32'h0000_beef;
    chk({gp_alloc_ok, gp_alloc_tag}, 5'h11);
    tick;
    gp_res_we = 0; flush = 1;
    tick;
    flush = 0; gp_use_imm = 1; gp_imm = 16'h8001;
    chk(gp_dat_a, 32'h0000_beef);
    tick;
    gp_use_imm = 0;
    chk(gp_dat_a, 32'hcafe_0005);
    chk({gp_rdy_b, gp_dat_b}, 33'h1_ffff_8001);
    $display("test gp done");
  endtask : t_gp
  task t_fp;
    fp_alloc_req = 1; fp_alloc_dst = 5'h02; fp_src_a = 5'h02; fp_src_b = 5'h1f;
    tick;
    fp_alloc_req = 0; fp_res_we = 1; fp_res_tag = fp_alloc_tag; fp_res_single = 1;
    fp_res_data = 64'h0123_4567_89ab_cdef;
    chk({fp_alloc_ok, fp_alloc_tag}, 4'h8);
    tick;
    fp_res_we = 0; fp_commit = 1;
    tick;
    fp_commit = 0;
    chk({fp_rdy_a, fp_single_a, fp_rdy_b}, 3'b111);
    tick;
    chk(fp_dat_a, 64'h0123_4567_89ab_cdef);
    chk({fp_single_b, fp_dat_b}, 65'h0);
    $display("test fp done");
  endtask : t_fp
  task t_cr;
    mv_cr_we = 1; mv_cr_mask = 8'hff; mv_cr_wdata = 32'h1234_5678; cr_fld_a = 3'h3;
    tick;
    mv_cr_we = 0; cr_alloc_req = 1; cr_alloc_fld = 3'h3;
    chk(condition_fields, 32'h1234_5678);
    tick;
    cr_alloc_req = 0; cr_res_we = 1; cr_res_tag = cr_alloc_tag; cr_res_data = 4'ha;
    chk({cr_alloc_ok, cr_alloc_tag, cr_test_a, cr_test_b}, 12'h841);
    tick;
    cr_res_we = 0; cr_commit = 1;
    chk({cr_rdy_a, cr_rdy_b}, 2'b01);
    tick;
    cr_commit = 0; mv_cr_we = 1; mv_cr_mask = 8'h01; mv_cr_wdata = 32'hffff_ffff;
    chk(condition_fields, 32'h123a_5678);
    tick;
    mv_cr_we = 0;
    chk(condition_fields, 32'hf23a_5678);
    $display("test cr done");
  endtask : t_cr
  task t_fsc;
    fsc_we = 1; fsc_wdata = 32'h0000_2000;
    tick;
    fsc_wdata = 32'h0000_0007; fp_exc_set = 5'h01;
    chk(float_status_control, 32'h0);
    tick;
    fsc_we = 0; fp_exc_set = '0;
    chk(float_status_control, 32'h0000_6107);
    $display("test fsc done");
  endtask : t_fsc
  task t_priv;
    sr_acc(1, SR_SCR_BASE, 32'ha5a5_0001);
    sr_acc(0, SR_SCR_BASE, 32'h0);
    chk({sr_rvalid, sr_rdata}, 33'h1_a5a5_0001);
    sr_acc(0, 10'h3ff, 32'h0);
    chk({sr_rvalid, sr_rdata}, 33'h1_0000_0000);
    op_64bit = 1;
    sr_acc(0, SR_SCR_BASE, 32'h0);
    op_64bit = 0;
    sr_re = 0;
    chk({illegal_op, sr_rvalid}, 2'b10);
    msw_we = 1; msw_wdata = 32'h0000_0002;
    tick;
    msw_wdata = 32'h0;
    chk(machine_state_word, 32'h0000_0002);
    tick;
    msw_we = 0;
    chk({priv_fault, machine_state_word}, 33'h1_0000_0002);
    sr_acc(1, SR_SCR_BASE, 32'h0bad_0001);
    chk(priv_fault, 1);
    sr_acc(0, SR_SAVE_IDX, 32'h0);
    sr_re = 0;
    chk({priv_fault, sr_rvalid}, 2'b10);
    exc_take = 1;
    tick;
    exc_take = 0;
    chk(machine_state_word[MSW_PRIV_BIT], 0);
    sr_acc(0, SR_SAVE_IDX, 32'h0);
    chk(sr_rdata, 32'h0000_0002);
    sr_acc(0, SR_SCR_BASE, 32'h0);
    sr_re = 0;
    chk(sr_rdata, 32'ha5a5_0001);
    exc_return = 1;
    tick;
    exc_return = 0;
    chk(machine_state_word, 32'h0000_0002);
    $display("test priv done");
  endtask : t_priv
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clock);
    #1 resetn = 1;
    chk({condition_fields, machine_state_word}, {CR_RESET, MSW_RESET});
    chk(float_status_control, FSC_RESET);
    t_gp;
    t_fp;
    t_cr;
    t_fsc;
    t_priv;
    report_and_stop;
  end
endmodule : risc_register_file_rename_test
`default_nettype wire
